//--- common/att_pkg.sv
// Purpose: Shared constants and types for the acquisition trigger timing block
// Assumes: APB slave, 32-bit data, one word per register, 100 MHz pclk
// Notes: Offsets and bit positions below are the only copies of these numbers, apart from the bench's literal status-clear masks and GO bit
package att_pkg;
    // ****************************************
    // Widths
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int DAC_W = 12;
    localparam int LEN_W = 4;
    localparam int CTRL_W = 12;
    localparam int N_SYNC = 4;
    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_INTERVAL = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_SCAN = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_SCAN_LEN = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_DAC0 = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_DAC1 = 8'h1c;
    // ****************************************
    // Control fields
    // ****************************************
    localparam int C_GO = 0;
    localparam int C_ABORT = 1;
    localparam int C_EXT_PACE = 2;
    localparam int C_MODE = 3;
    localparam int C_CONV_OUT = 5;
    localparam int C_SCAN_EN = 6;
    localparam int C_EXT_SCAN = 7;
    localparam int C_DELAYED = 8;
    localparam int C_UPD_IE = 9;
    localparam int C_DONE_IE = 10;
    localparam int C_COUNTED = 11;
    localparam logic [CTRL_W-1:0] CTRL_ACT_MASK = 12'h003;
    localparam logic [1:0] MODE_SOFT = 2'h0;
    localparam logic [1:0] MODE_START = 2'h1;
    localparam logic [1:0] MODE_STOP = 2'h2;
    // ****************************************
    // Status fields
    // ****************************************
    localparam int S_RUN = 0;
    localparam int S_TRIG = 1;
    localparam int S_DONE = 2;
    localparam int S_UPD = 3;
    localparam int S_TC = 4;
    localparam int S_GATE = 5;
    localparam int S_ERR = 6;
    localparam int S_CNT_LO = 16;
    // ****************************************
    // Synchroniser lanes and reset values
    // ****************************************
    localparam int I_CONV = 0;
    localparam int I_TRIG = 1;
    localparam int I_SCAN = 2;
    localparam int I_UPD = 3;
    localparam logic [N_SYNC-1:0] SYNC_RST = 4'h9;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] RST_INTERVAL = 16'h0064;
    localparam logic [CNT_W-1:0] RST_COUNT = 16'h0001;
    localparam logic [CNT_W-1:0] RST_SCAN = 16'h03e8;
    localparam logic [LEN_W-1:0] LEN_ONE = 4'h1;
    // ****************************************
    // Timing of external sources
    // ****************************************
    localparam int CLK_NS = 10;
    localparam int T_EXT_MIN_NS = 50;
    localparam int EXT_MIN_CYC = (T_EXT_MIN_NS + CLK_NS - 1) / CLK_NS;
    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WTRIG = 4'h2,
        ST_ARM = 4'h4,
        ST_RUN = 4'h8
    } att_state_t;
endpackage

//--- core/att_top.sv
// Purpose: Conversion pacing, trigger handling, scan gating and DAC update
// Assumes: External pins are synchronised here; ADC and DACs sit outside
// Notes: APB answers in the second access cycle; no wait beyond that
`timescale 1ns/10ps

// Summary of operation
// - A dedicated interval counter paces conversions; software cannot reuse it.
// - A dedicated sample counter counts conversions and stops the acquisition.
// - With external pacing each convert falling edge starts one conversion.
// - The convert pin can be an output carrying a conversion strobe.
// - Software picks start-on-trigger or stop-on-trigger, never both.
// - Start mode, internal pacing: trigger rise starts counter and sequence.
// - Start mode, external pacing: trigger then convert rise arms; next fall converts.
// - After the first accepted trigger further trigger edges are ignored.
// - Stop mode: conversions start at once; counter waits for trigger rise.
// - Stop mode: conversions continue until the sample counter reaches zero.
// - Up to 65536 samples after the trigger; before it unlimited.
// - Scan interval from a scan counter or an external scan pulse.
// - External pacing: first convert rise after scan pulse opens the gate; next fall converts.
// - Gate closes after the scan's channels; conversions blocked till next scan.
// - Immediate mode: DAC output follows each write.
// - Delayed mode: output held until update input low drives update strobe.
// - Update interrupt on every update input rising edge when enabled.
// - Enabled, clearable interrupt when an acquisition completes or overruns.
module att_top
    import att_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [att_pkg::ADDR_W-1:0] paddr,
    input wire logic [att_pkg::DATA_W-1:0] pwdata,
    output logic [att_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // External timing pins
    input wire logic ext_convert_n_i,
    output logic ext_convert_n_o,
    output logic ext_convert_n_oe,
    input wire logic ext_acq_trigger,
    input wire logic scan_interval_pulse,
    input wire logic ext_dac_update_n,
    // ADC side
    input wire logic adc_overrun,
    output logic adc_convert,
    // DAC side
    output logic dac_write_strobe,
    output logic dac_update,
    output logic [att_pkg::DAC_W-1:0] dac0_out,
    output logic [att_pkg::DAC_W-1:0] dac1_out,
    // Interrupt
    output logic update_interrupt
);
    import att_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [N_SYNC-1:0] s1, s2, s3;
        att_state_t st;
        logic [CTRL_W-1:0] ctrl;
        logic [CNT_W-1:0] si_load, sc_load, scan_load;
        logic [LEN_W-1:0] scan_len;
        logic [CNT_W-1:0] si_cnt, sc_cnt, scan_cnt;
        logic [LEN_W-1:0] chan_cnt;
        logic trig_seen, tc, gate, scan_pend, done_flag, upd_flag, err_flag;
        logic [DAC_W-1:0] dac0_hold, dac1_hold, dac0_out, dac1_out;
        logic dac_upd, dac_wr, adc_conv, conv_o_n, irq, pready, pslverr;
        logic [DATA_W-1:0] prdata;
    } att_regs_t;

    att_regs_t r_reg;
    att_regs_t r_next;

    function automatic logic att_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction

    function automatic logic att_mapped(input logic [ADDR_W-1:0] a);
        return att_hit(a, OFF_CTRL) | att_hit(a, OFF_INTERVAL) | att_hit(a, OFF_COUNT) |
               att_hit(a, OFF_SCAN) | att_hit(a, OFF_SCAN_LEN) | att_hit(a, OFF_STATUS) |
               att_hit(a, OFF_DAC0) | att_hit(a, OFF_DAC1);
    endfunction

    // ****************************************
    // Helper terms
    // ****************************************
    logic wr_w, go_w, abort_w, ext_pace_w, scan_en_w;
    logic [N_SYNC-1:0] rise_w, fall_w;
    logic [1:0] mode_w;

    // Write lands only at the edge where the master sees pready high
    assign wr_w = psel & penable & r_reg.pready & pwrite;
    assign go_w = wr_w & att_hit(paddr, OFF_CTRL) & pwdata[C_GO];
    assign abort_w = wr_w & att_hit(paddr, OFF_CTRL) & pwdata[C_ABORT];
    // Edges read the second and third stages only
    assign rise_w = r_reg.s2 & ~r_reg.s3;
    assign fall_w = ~r_reg.s2 & r_reg.s3;
    assign mode_w = r_reg.ctrl[C_MODE +: 2];
    // Driving the pin ourselves would read back our own strobe as pacing
    assign ext_pace_w = r_reg.ctrl[C_EXT_PACE] & ~r_reg.ctrl[C_CONV_OUT];
    assign scan_en_w = r_reg.ctrl[C_SCAN_EN];

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic pace_tick, scan_tick, count_on;
        pace_tick = 1'b0;
        scan_tick = 1'b0;
        count_on = 1'b0;
        r_next = r_reg;
        r_next.s1 = {ext_dac_update_n, scan_interval_pulse, ext_acq_trigger, ext_convert_n_i};
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        r_next.adc_conv = 1'b0;
        r_next.conv_o_n = 1'b1;
        r_next.dac_wr = 1'b0;
        r_next.pready = 1'b0;
        r_next.pslverr = 1'b0;

        // APB access: answer on the second access cycle
        if (psel && penable && !r_reg.pready) begin
            r_next.pready = 1'b1;
            r_next.pslverr = ~att_mapped(paddr);
            if (!pwrite) begin
                r_next.prdata = '0;
                case (paddr)
                    OFF_CTRL: r_next.prdata[CTRL_W-1:0] = r_reg.ctrl;
                    OFF_INTERVAL: r_next.prdata[CNT_W-1:0] = r_reg.si_load;
                    OFF_COUNT: r_next.prdata[CNT_W-1:0] = r_reg.sc_load;
                    OFF_SCAN: r_next.prdata[CNT_W-1:0] = r_reg.scan_load;
                    OFF_SCAN_LEN: r_next.prdata[LEN_W-1:0] = r_reg.scan_len;
                    OFF_STATUS: begin
                        r_next.prdata[S_RUN] = r_reg.st != ST_IDLE;
                        r_next.prdata[S_TRIG] = r_reg.trig_seen;
                        r_next.prdata[S_DONE] = r_reg.done_flag;
                        r_next.prdata[S_UPD] = r_reg.upd_flag;
                        r_next.prdata[S_TC] = r_reg.tc;
                        r_next.prdata[S_GATE] = r_reg.gate;
                        r_next.prdata[S_ERR] = r_reg.err_flag;
                        r_next.prdata[S_CNT_LO +: CNT_W] = r_reg.sc_cnt;
                    end
                    OFF_DAC0: r_next.prdata[DAC_W-1:0] = r_reg.dac0_hold;
                    OFF_DAC1: r_next.prdata[DAC_W-1:0] = r_reg.dac1_hold;
                    default: r_next.prdata = '0;
                endcase
            end
        end

        if (wr_w) begin
            case (paddr)
                OFF_CTRL: r_next.ctrl = pwdata[CTRL_W-1:0] & ~CTRL_ACT_MASK;
                OFF_INTERVAL: r_next.si_load = pwdata[CNT_W-1:0];
                OFF_COUNT: r_next.sc_load = pwdata[CNT_W-1:0];
                OFF_SCAN: r_next.scan_load = pwdata[CNT_W-1:0];
                OFF_SCAN_LEN: r_next.scan_len = pwdata[LEN_W-1:0];
                OFF_STATUS: begin
                    // Clear first so a same-cycle event below still sets
                    r_next.done_flag = r_reg.done_flag & ~pwdata[S_DONE];
                    r_next.upd_flag = r_reg.upd_flag & ~pwdata[S_UPD];
                    r_next.err_flag = r_reg.err_flag & ~pwdata[S_ERR];
                end
                OFF_DAC0: begin
                    r_next.dac0_hold = pwdata[DAC_W-1:0];
                    r_next.dac_wr = 1'b1;
                end
                OFF_DAC1: begin
                    r_next.dac1_hold = pwdata[DAC_W-1:0];
                    r_next.dac_wr = 1'b1;
                end
                default: r_next.ctrl = r_reg.ctrl;
            endcase
        end

        // Pacing source: pin falling edge or the interval counter at zero
        pace_tick = ext_pace_w ? fall_w[I_CONV] : (r_reg.si_cnt == '0);
        scan_tick = r_reg.ctrl[C_EXT_SCAN] ? rise_w[I_SCAN] : (r_reg.scan_cnt == '0);
        // Stop mode counts only after the trigger; other modes when counted
        count_on = (mode_w == MODE_STOP) ? r_reg.trig_seen : r_reg.ctrl[C_COUNTED];

        case (r_reg.st)
            ST_IDLE: r_next.st = ST_IDLE;
            ST_WTRIG: begin
                if (rise_w[I_TRIG]) begin
                    r_next.trig_seen = 1'b1;
                    if (ext_pace_w) begin
                        r_next.st = ST_ARM;
                    end else begin
                        r_next.st = ST_RUN;
                        r_next.si_cnt = r_reg.si_load - CNT_ONE;
                    end
                end
            end
            ST_ARM: begin
                if (rise_w[I_CONV]) begin
                    r_next.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!ext_pace_w) begin
                    r_next.si_cnt = (r_reg.si_cnt == '0) ? r_reg.si_load - CNT_ONE
                                                         : r_reg.si_cnt - CNT_ONE;
                end
                // Only the first trigger edge of a sequence counts
                if (mode_w == MODE_STOP && !r_reg.trig_seen && rise_w[I_TRIG]) begin
                    r_next.trig_seen = 1'b1;
                end
                if (scan_en_w) begin
                    if (!r_reg.ctrl[C_EXT_SCAN]) begin
                        r_next.scan_cnt = (r_reg.scan_cnt == '0) ? r_reg.scan_load - CNT_ONE
                                                                 : r_reg.scan_cnt - CNT_ONE;
                    end
                    if (scan_tick) begin
                        r_next.scan_pend = 1'b1;
                        r_next.chan_cnt = '0;
                    end
                    // Internal pacing opens at once; external waits for a rise
                    if (r_reg.scan_pend && (rise_w[I_CONV] || !ext_pace_w)) begin
                        r_next.gate = 1'b1;
                        r_next.scan_pend = 1'b0;
                    end
                end
                if (pace_tick && (!scan_en_w || r_reg.gate)) begin
                    r_next.adc_conv = 1'b1;
                    r_next.conv_o_n = 1'b0;
                    if (scan_en_w) begin
                        if (r_reg.chan_cnt == r_reg.scan_len - LEN_ONE) begin
                            r_next.gate = 1'b0;
                        end else begin
                            r_next.chan_cnt = r_reg.chan_cnt + LEN_ONE;
                        end
                    end
                    if (count_on) begin
                        r_next.sc_cnt = r_reg.sc_cnt - CNT_ONE;
                        if (r_reg.sc_cnt == CNT_ONE) begin
                            r_next.tc = 1'b1;
                            r_next.st = ST_IDLE;
                            r_next.done_flag = 1'b1;
                        end
                    end
                end
                if (adc_overrun) begin
                    r_next.err_flag = 1'b1;
                    r_next.done_flag = 1'b1;
                    r_next.st = ST_IDLE;
                end
            end
            default: r_next.st = ST_IDLE;
        endcase

        // GO obeys the mode written alongside it; re-arms the trigger, reloads interval and sample counters, zeroes the scan counter
        if (go_w) begin
            r_next.st = (pwdata[C_MODE +: 2] == MODE_START) ? ST_WTRIG : ST_RUN;
            r_next.trig_seen = 1'b0;
            r_next.tc = 1'b0;
            r_next.sc_cnt = r_reg.sc_load;
            r_next.si_cnt = r_reg.si_load - CNT_ONE;
            r_next.scan_cnt = '0;
            r_next.scan_pend = 1'b0;
            r_next.gate = 1'b0;
            r_next.chan_cnt = '0;
        end
        if (abort_w) begin
            r_next.st = ST_IDLE;
        end

        // DAC update: write-driven or held for the update input low level
        if (r_reg.ctrl[C_DELAYED]) begin
            r_next.dac_upd = ~r_reg.s2[I_UPD];
        end else begin
            r_next.dac_upd = r_reg.dac_wr;
        end
        if (r_next.dac_upd) begin
            r_next.dac0_out = r_reg.dac0_hold;
            r_next.dac1_out = r_reg.dac1_hold;
        end
        if (rise_w[I_UPD] && r_reg.ctrl[C_UPD_IE]) begin
            r_next.upd_flag = 1'b1;
        end
        r_next.irq = (r_next.upd_flag & r_next.ctrl[C_UPD_IE]) |
                     (r_next.done_flag & r_next.ctrl[C_DONE_IE]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
            r_reg.s1 <= SYNC_RST;
            r_reg.s2 <= SYNC_RST;
            r_reg.s3 <= SYNC_RST;
            r_reg.st <= ST_IDLE;
            r_reg.si_load <= RST_INTERVAL;
            r_reg.sc_load <= RST_COUNT;
            r_reg.scan_load <= RST_SCAN;
            r_reg.scan_len <= LEN_ONE;
            r_reg.conv_o_n <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign ext_convert_n_o = r_reg.conv_o_n;
    assign ext_convert_n_oe = r_reg.ctrl[C_CONV_OUT];
    assign adc_convert = r_reg.adc_conv;
    assign dac_write_strobe = r_reg.dac_wr;
    assign dac_update = r_reg.dac_upd;
    assign dac0_out = r_reg.dac0_out;
    assign dac1_out = r_reg.dac1_out;
    assign update_interrupt = r_reg.irq;

    // ****************************************
    // Checks
    // ****************************************
    default clocking att_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_conv_in_run: assert property (r_reg.adc_conv |-> $past(r_reg.st) == ST_RUN)
        else $error("conversion outside a running sequence");
    a_ext_fall_conv: assert property ((r_reg.st == ST_RUN) && ext_pace_w && !scan_en_w &&
        fall_w[I_CONV] && !go_w && !abort_w |=> r_reg.adc_conv)
        else $error("convert falling edge did not start a conversion");
    a_tc_stops: assert property ($rose(r_reg.tc) |->
        r_reg.st == ST_IDLE && r_reg.sc_cnt == '0)
        else $error("terminal count without stop at zero");
    a_wait_no_conv: assert property ((r_reg.st == ST_WTRIG) |=> !r_reg.adc_conv)
        else $error("conversion before trigger in start mode");
    a_arm_then_run: assert property ((r_reg.st == ST_ARM) && rise_w[I_CONV] &&
        !go_w && !abort_w |=> r_reg.st == ST_RUN ##0 !r_reg.adc_conv)
        else $error("arming edge did not enter run");
    a_trig_held: assert property (r_reg.trig_seen && !go_w |=> r_reg.trig_seen)
        else $error("accepted trigger was lost");
    a_pre_halted: assert property ((r_reg.st == ST_RUN) && (mode_w == MODE_STOP) &&
        !r_reg.trig_seen && !go_w |=> $stable(r_reg.sc_cnt))
        else $error("sample counter moved before trigger");
    a_gate_blocks: assert property ((r_reg.st == ST_RUN) && scan_en_w && !r_reg.gate
        |=> !r_reg.adc_conv)
        else $error("conversion with scan gate closed");
    a_dac_held: assert property (r_reg.ctrl[C_DELAYED] && r_reg.s2[I_UPD] |=>
        $stable(r_reg.dac0_out) && $stable(r_reg.dac1_out))
        else $error("delayed DAC output changed without update low");
    a_upd_irq: assert property (rise_w[I_UPD] && r_reg.ctrl[C_UPD_IE] && !wr_w |=>
        r_reg.upd_flag && update_interrupt)
        else $error("update rising edge missed its interrupt");
    a_strobe_out: assert property (r_reg.adc_conv |-> !ext_convert_n_o)
        else $error("conversion without strobe on convert pin");
endmodule

//--- dv/att_src.sv
// Purpose: Far-side timing sources: convert, trigger, scan and update pins
// Assumes: Tasks are called just after a rising pclk edge
// Notes: Pins idle inactive; trigger, scan and update pulses last EXT_MIN_CYC + 1 cycles, convert levels 4 cycles
`timescale 1ns/10ps
module att_src
    import att_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Timing pins
    output logic conv_n,
    output logic trig,
    output logic scan,
    output logic upd_n
);
    initial begin
        conv_n = 1'b1;
        trig = 1'b0;
        scan = 1'b0;
        upd_n = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Both levels outlast the synchroniser so each edge is seen once
    task automatic conv_pulse();
        conv_n <= 1'b0;
        hold(4);
        conv_n <= 1'b1;
        hold(4);
    endtask
    // Trigger leads any arming convert rise by more than the minimum gap
    task automatic trig_pulse();
        trig <= 1'b1;
        hold(EXT_MIN_CYC + 1);
        trig <= 1'b0;
        hold(4);
    endtask
    // Any convert rise that follows lands well past the minimum gap
    task automatic scan_pulse();
        scan <= 1'b1;
        hold(EXT_MIN_CYC + 1);
        scan <= 1'b0;
        hold(4);
    endtask
    // Short low pulse, yet longer than the minimum width
    task automatic upd_pulse();
        upd_n <= 1'b0;
        hold(EXT_MIN_CYC + 1);
        upd_n <= 1'b1;
        hold(4);
    endtask
endmodule

//--- dv/att_top_bench.sv
// Purpose: Self-checking bench for trigger, pacing and DAC update behaviour
// Assumes: APB answers within 16 access cycles; overrun input held idle
// Notes: Conversions are counted at adc_convert; expectations are counts
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t got %h expected %h", $time, (a), (e)); end end
module att_top_bench;
    import att_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, cv_o, cv_oe, src_cv, trig, scan, upd_n;
    logic adc_convert, dac_write_strobe, dac_update, update_interrupt;
    logic [DAC_W-1:0] dac0_out, dac1_out;
    int bad_count = 0, compares = 0, convs = 0, strobes = 0, dws = 0, dups = 0;
    localparam logic [31:0] STRT = 32'(MODE_START) << C_MODE;
    localparam logic [31:0] STOP = 32'(MODE_STOP) << C_MODE;
    localparam logic [31:0] EXTP = 32'h1 << C_EXT_PACE;
    localparam logic [31:0] CNTD = 32'h1 << C_COUNTED;
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        if (adc_convert === 1'b1) convs++;
        if (cv_o === 1'b0 && cv_oe === 1'b1) strobes++;
        if (dac_write_strobe === 1'b1) dws++;
        if (dac_update === 1'b1) dups++;
    end
    att_top u_att_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_convert_n_i(cv_oe ? cv_o : src_cv), .ext_convert_n_o(cv_o),
        .ext_convert_n_oe(cv_oe), .ext_acq_trigger(trig), .scan_interval_pulse(scan),
        .ext_dac_update_n(upd_n), .adc_overrun(1'b0), .adc_convert(adc_convert),
        .dac_write_strobe(dac_write_strobe), .dac_update(dac_update),
        .dac0_out(dac0_out), .dac1_out(dac1_out), .update_interrupt(update_interrupt));
    att_src u_src (.pclk(pclk), .conv_n(src_cv), .trig(trig), .scan(scan), .upd_n(upd_n));
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // One APB transfer, then an idle cycle so the next setup never collides
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin bad_count++; results(); end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic go(input logic [31:0] c, input logic [15:0] iv, input logic [15:0] cnt);
        apb(1'b1, OFF_INTERVAL, {16'h0, iv});
        apb(1'b1, OFF_COUNT, {16'h0, cnt});
        convs = 0;
        apb(1'b1, OFF_CTRL, c | 32'h1);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin apb(1'b0, OFF_STATUS, 0); n++; end while (rd[S_DONE] !== 1'b1 && n < 100);
        if (rd[S_DONE] !== 1'b1) begin bad_count++; results(); end
        `CHK(rd[S_TC], 1'b1)
    endtask
    task automatic t_regs();
        apb(1'b0, OFF_INTERVAL, 0);
        `CHK(rd, {16'h0, RST_INTERVAL})
        apb(1'b0, OFF_SCAN, 0);
        `CHK(rd, 32'h3e8)
        apb(1'b1, 8'hfc, 32'h1);
        `CHK(err, 1'b1)
    endtask
    task automatic t_start_int();
        go(STRT | CNTD | (32'h1 << C_CONV_OUT) | (32'h1 << C_DONE_IE), 16'h14, 16'h3);
        cyc(40);
        `CHK(convs, 0)
        u_src.trig_pulse();
        wait_done();
        `CHK(convs, 3)
        `CHK(strobes, 3)
        `CHK(update_interrupt, 1'b1)
        apb(1'b1, OFF_STATUS, 32'h4c);
        cyc(2);
        `CHK(update_interrupt, 1'b0)
        u_src.trig_pulse();
        cyc(100);
        `CHK(convs, 3)
    endtask
    task automatic t_start_ext();
        go(STRT | CNTD | EXTP, 16'h14, 16'h2);
        u_src.conv_pulse();
        `CHK(convs, 0)
        u_src.trig_pulse();
        repeat (3) u_src.conv_pulse();
        wait_done();
        `CHK(convs, 2)
    endtask
    task automatic t_stop_ext();
        go(STOP | EXTP, 16'h14, 16'h2);
        repeat (3) u_src.conv_pulse();
        `CHK(convs, 3)
        u_src.trig_pulse();
        repeat (4) u_src.conv_pulse();
        `CHK(convs, 5)
        wait_done();
        apb(1'b1, OFF_STATUS, 32'h4c);
    endtask
    // External scan and pacing together; each scan converts SCAN_LEN channels
    task automatic t_scan();
        apb(1'b1, OFF_SCAN_LEN, 32'h2);
        go(EXTP | (32'h1 << C_SCAN_EN) | (32'h1 << C_EXT_SCAN), 16'h14, 16'h0);
        for (int i = 1; i <= 2; i++) begin
            u_src.scan_pulse();
            repeat (4) u_src.conv_pulse();
            `CHK(convs, 2 * i)
        end
        `CHK(convs, 4)
        apb(1'b1, OFF_CTRL, 32'h1 << C_ABORT);
    endtask
    task automatic t_dac();
        apb(1'b1, OFF_CTRL, 32'h0);
        apb(1'b1, OFF_DAC0, 32'h5a3);
        cyc(4);
        `CHK(dac0_out, 12'h5a3)
        `CHK(dws, 1)
        `CHK(dups, 1)
        apb(1'b1, OFF_CTRL, (32'h1 << C_DELAYED) | (32'h1 << C_UPD_IE));
        apb(1'b1, OFF_DAC1, 32'h3c1);
        cyc(20);
        `CHK(dac1_out, 12'h000)
        `CHK(dws, 2)
        `CHK(dups, 1)
        `CHK(update_interrupt, 1'b0)
        u_src.upd_pulse();
        `CHK(dac1_out, 12'h3c1)
        `CHK(dups, 1 + EXT_MIN_CYC + 1)
        `CHK(update_interrupt, 1'b1)
        apb(1'b1, OFF_STATUS, 32'h8);
        cyc(2);
        `CHK(update_interrupt, 1'b0)
    endtask
    initial begin
        cyc(20);
        presetn <= 1'b1;
        cyc(1);
        t_regs();
        t_start_int();
        t_start_ext();
        t_stop_ext();
        t_scan();
        t_dac();
        results();
    end
endmodule
